// [hw/csr_consts.vh]
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH
// register offsets on the plain register port
`define CSR_OFS_BANK      8'h04
`define CSR_OFS_WORK      8'h05
`define CSR_OFS_PCL       8'h06
`define CSR_OFS_TBL_LO    8'h07
`define CSR_OFS_TBL_HI    8'h08
`define CSR_OFS_TBL_HB    8'h09
`define CSR_OFS_STATUS    8'h0a
// special function area ends here
`define CSR_SFR_LAST      8'h7f
// status field positions
`define CSR_ST_C          0
`define CSR_ST_AC         1
`define CSR_ST_Z          2
`define CSR_ST_OV         3
`define CSR_ST_PDF        4
`define CSR_ST_TO         5
// reset values
`define CSR_RST_BANK      2'h0
`define CSR_RST_BYTE      8'h00
// alu operation codes
`define CSR_ALU_ADD       3'h0
`define CSR_ALU_SUB       3'h1
`define CSR_ALU_AND       3'h2
`define CSR_ALU_OR        3'h3
`define CSR_ALU_XOR       3'h4
`define CSR_ALU_RLC       3'h5
`define CSR_ALU_RRC       3'h6
`define CSR_ALU_MOV       3'h7
`endif

// [hw/csr_core_regs.v]
// Function
// - three-bank select codes 00,01,10 pick banks 0,1,2; 11 undefined
// - two-bank variant keeps only bit 0 writable, bits 7-1 read zero
// - three-bank variant keeps bits 1-0 writable, bits 7-2 read zero
// - any reset returns bank to 0 except watchdog reset in power-down
// - special function area reaches same registers from every bank
// - direct data accesses always go to bank 0
// - other banks reachable only through indirect addressing with bank select
// - alu results land in work register; register moves pass through it
// - writing pc low byte jumps within current page, upper bits kept
// - a pc low byte write inserts one dummy cycle before target executes
// - table read puts high byte in table high register, low byte out
// - status writes change arithmetic flags, never timeout or sleep flags
// - timeout flag bit 5 set by watchdog, cleared by power-up, clear, sleep
// - sleep flag bit 4 set by sleep, cleared by power-up or watchdog clear
// - carry bit 0 from add carry, subtract no-borrow, rotate through carry
// - nibble carry bit 1 from low nibble carry or no nibble borrow
// - zero flag bit 2 set when result is zero
// - signed wrap bit 3 when carry into msb differs from carry out
// - status is not saved on interrupt or call; software saves it
// - timeout and sleep flags zero at power-on; bits 7-6 read zero
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "csr_consts.vh"
module csr_core_regs #(
  parameter THREE_BANK = 1,
  parameter PC_W       = 13
) (
  // clock and power-up reset
  input  wire            mclk,
  input  wire            nrst,
  // register port
  input  wire [7:0]      reg_addr,
  input  wire [7:0]      reg_wdata,
  input  wire            reg_wr,
  input  wire            reg_rd,
  output reg  [7:0]      reg_rdata,
  // data memory address mapping
  input  wire [7:0]      dm_addr,
  input  wire            dm_indirect,
  output wire [1:0]      dm_bank,
  output wire            dm_sfr_hit,
  // alu operation from the core
  input  wire            alu_go,
  input  wire [2:0]      alu_op,
  input  wire [7:0]      alu_opnd,
  input  wire            alu_to_work,
  output wire [7:0]      alu_result,
  // system events
  input  wire            wdt_timeout,
  input  wire            wdt_clear,
  input  wire            sleep_exec,
  input  wire            wdt_reset_in_sleep,
  input  wire            soft_reset,
  // program counter
  input  wire            pc_step,
  output wire [PC_W-1:0] pc_value,
  output wire            pc_dummy,
  // table read
  input  wire            tbl_go,
  output wire [15:0]     tbl_addr,
  input  wire [15:0]     tbl_word,
  output reg  [7:0]      tbl_low_byte,
  output reg             tbl_low_valid
);

  localparam [1:0] BANK_MASK = THREE_BANK ? 2'h3 : 2'h1;

  reg [1:0]      bank_r;
  reg [7:0]      work_r;
  reg [PC_W-1:0] pc_r;
  reg            dummy_r;
  reg [7:0]      tbl_lo_r;
  reg [7:0]      tbl_hi_r;
  reg [7:0]      tbl_hb_r;
  reg [3:0]      flags_r;
  reg            to_r;
  reg            pdf_r;

  // full alu: result, carry, nibble carry, wrap
  function [10:0] alu_f;
    input [2:0] op;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [8:0] s;
    reg   [4:0] n;
    reg         c7;
    begin
      s = 9'h000;
      n = 5'h00;
      c7 = 1'b0;
      alu_f = {3'h0, a};
      case (op)
        `CSR_ALU_ADD:
        begin
          s = {1'b0, a} + {1'b0, b};
          n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
          c7 = s[7] ^ a[7] ^ b[7];
          alu_f = {c7 ^ s[8], n[4], s[8], s[7:0]};
        end
        `CSR_ALU_SUB:
        begin
          s = {1'b0, a} + {1'b0, ~b} + 9'h001;
          n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
          c7 = s[7] ^ a[7] ^ ~b[7];
          alu_f = {c7 ^ s[8], n[4], s[8], s[7:0]};
        end
        `CSR_ALU_AND: alu_f = {3'h0, a & b};
        `CSR_ALU_OR:  alu_f = {3'h0, a | b};
        `CSR_ALU_XOR: alu_f = {3'h0, a ^ b};
        `CSR_ALU_RLC: alu_f = {2'h0, b[7], b[6:0], cin};
        `CSR_ALU_RRC: alu_f = {2'h0, b[0], cin, b[7:1]};
        default:      alu_f = {3'h0, b};
      endcase
    end
  endfunction

  // address decode helper
  function hit_f;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit_f = (a == ofs);
    end
  endfunction

  wire [10:0] alu_w = alu_f(alu_op, work_r, alu_opnd, flags_r[`CSR_ST_C]);
  wire        arith = (alu_op == `CSR_ALU_ADD) || (alu_op == `CSR_ALU_SUB);
  wire        rot   = (alu_op == `CSR_ALU_RLC) || (alu_op == `CSR_ALU_RRC);
  wire        flag_logic = (alu_op == `CSR_ALU_AND) || (alu_op == `CSR_ALU_OR) ||
                           (alu_op == `CSR_ALU_XOR);
  wire        alu_zero = (alu_w[7:0] == 8'h00);

  // decoded register writes
  wire        wr_bank = reg_wr && hit_f(reg_addr, `CSR_OFS_BANK);
  wire        wr_work = reg_wr && hit_f(reg_addr, `CSR_OFS_WORK);
  wire        wr_pcl  = reg_wr && hit_f(reg_addr, `CSR_OFS_PCL);
  wire        wr_tlo  = reg_wr && hit_f(reg_addr, `CSR_OFS_TBL_LO);
  wire        wr_thi  = reg_wr && hit_f(reg_addr, `CSR_OFS_TBL_HI);
  wire        wr_stat = reg_wr && hit_f(reg_addr, `CSR_OFS_STATUS);

  // next values of every register except the table valid flag
  reg [1:0]      bank_nxt;
  reg [7:0]      work_nxt;
  reg [PC_W-1:0] pc_nxt;
  reg            dummy_nxt;
  reg [7:0]      tbl_lo_nxt;
  reg [7:0]      tbl_hi_nxt;
  reg [7:0]      tbl_hb_nxt;
  reg [7:0]      low_byte_nxt;
  reg [3:0]      flags_nxt;
  reg            to_nxt;
  reg            pdf_nxt;
  reg [7:0]      rdata_nxt;

  assign alu_result = alu_w[7:0];

  // bank mapping for the data memory
  assign dm_sfr_hit = (dm_addr <= `CSR_SFR_LAST);
  assign dm_bank    = (dm_sfr_hit || !dm_indirect) ? 2'h0 :
                      bank_r;
  assign pc_value   = pc_r;
  assign pc_dummy   = dummy_r;
  assign tbl_addr   = {tbl_hi_r, tbl_lo_r};

  // bank select next value, soft reset spared in power-down
  always @*
  begin
    bank_nxt = bank_r;
    if (soft_reset && !wdt_reset_in_sleep)
      bank_nxt = `CSR_RST_BANK;
    else if (wr_bank)
      bank_nxt = reg_wdata[1:0] & BANK_MASK;
  end

  // bank select register
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      bank_r <= `CSR_RST_BANK;
    else
      bank_r <= bank_nxt;
  end

  // work register next value: software write first, then alu result
  always @*
  begin
    work_nxt = work_r;
    if (wr_work)
      work_nxt = reg_wdata;
    else if (alu_go && alu_to_work)
      work_nxt = alu_w[7:0];
  end

  // work register
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      work_r <= `CSR_RST_BYTE;
    else
      work_r <= work_nxt;
  end

  // program counter next value: low byte write jumps within the page
  always @*
  begin
    dummy_nxt = wr_pcl;
    pc_nxt = pc_r;
    if (wr_pcl)
      pc_nxt = {pc_r[PC_W-1:8], reg_wdata};
    else if (pc_step && !dummy_r)
      pc_nxt = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
  end

  // program counter and dummy cycle marker
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pc_r <= {PC_W{1'b0}};
      dummy_r <= 1'b0;
    end
    else
    begin
      pc_r <= pc_nxt;
      dummy_r <= dummy_nxt;
    end
  end

  // table pointers and table read next values
  always @*
  begin
    tbl_lo_nxt = wr_tlo ? reg_wdata : tbl_lo_r;
    tbl_hi_nxt = wr_thi ? reg_wdata : tbl_hi_r;
    tbl_hb_nxt = tbl_go ? tbl_word[15:8] : tbl_hb_r;
    low_byte_nxt = tbl_go ? tbl_word[7:0] : tbl_low_byte;
  end

  // table pointers and table read
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tbl_lo_r <= `CSR_RST_BYTE;
      tbl_hi_r <= `CSR_RST_BYTE;
      tbl_hb_r <= `CSR_RST_BYTE;
      tbl_low_byte <= `CSR_RST_BYTE;
      tbl_low_valid <= 1'b0;
    end
    else
    begin
      tbl_lo_r <= tbl_lo_nxt;
      tbl_hi_r <= tbl_hi_nxt;
      tbl_hb_r <= tbl_hb_nxt;
      tbl_low_byte <= low_byte_nxt;
      tbl_low_valid <= tbl_go;
    end
  end

  // arithmetic flags next value: alu update wins over a status write
  always @*
  begin
    flags_nxt = flags_r;                                      // no copy kept
    if (alu_go && arith)
      flags_nxt = {alu_w[10], alu_zero, alu_w[9], alu_w[8]};
    else if (alu_go && rot)
      flags_nxt[`CSR_ST_C] = alu_w[8];
    else if (alu_go && flag_logic)
      flags_nxt[`CSR_ST_Z] = alu_zero;
    else if (wr_stat)
      flags_nxt = reg_wdata[3:0];
  end

  // arithmetic flags
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      flags_r <= 4'h0;
    else
      flags_r <= flags_nxt;
  end

  // timeout flag next value, set wins over clear
  always @*
  begin
    to_nxt = to_r;
    if (wdt_timeout)
      to_nxt = 1'b1;
    else if (wdt_clear || sleep_exec)
      to_nxt = 1'b0;
  end

  // sleep flag next value, set wins over clear
  always @*
  begin
    pdf_nxt = pdf_r;
    if (sleep_exec)
      pdf_nxt = 1'b1;
    else if (wdt_clear)
      pdf_nxt = 1'b0;
  end

  // system flags, untouched by status writes
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      to_r <= 1'b0;
      pdf_r <= 1'b0;
    end
    else
    begin
      to_r <= to_nxt;
      pdf_r <= pdf_nxt;
    end
  end

  // read data mux, zero outside a read
  always @*
  begin
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `CSR_OFS_BANK:   rdata_nxt = {6'h00, bank_r};
        `CSR_OFS_WORK:   rdata_nxt = work_r;
        `CSR_OFS_PCL:    rdata_nxt = pc_r[7:0];
        `CSR_OFS_TBL_LO: rdata_nxt = tbl_lo_r;
        `CSR_OFS_TBL_HI: rdata_nxt = tbl_hi_r;
        `CSR_OFS_TBL_HB: rdata_nxt = tbl_hb_r;
        `CSR_OFS_STATUS: rdata_nxt = {2'h0, to_r, pdf_r, flags_r};
        default:         rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data one cycle after the strobe
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_nxt;
  end

endmodule

// [test/cpu_core_special_registers_tb_top.sv]
`timescale 1ns/100ps
module cpu_core_special_registers_tb_top;
  reg         mclk, nrst, reg_wr, reg_rd, dm_indirect, alu_go, alu_to_work, tbl_go;
  reg         wdt_reset_in_sleep, pc_step;
  reg  [7:0]  reg_addr, reg_wdata, dm_addr, alu_opnd, a, b, d, d2, res;
  wire [7:0]  rdata2;
  wire [1:0]  bank2;
  reg  [2:0]  alu_op;
  reg  [3:0]  ev;
  wire [7:0]  reg_rdata, alu_result, tbl_low_byte;
  wire [1:0]  dm_bank;
  wire [12:0] pc_value;
  wire [15:0] tbl_addr, tbl_word;
  wire        dm_sfr_hit, pc_dummy, tbl_low_valid;
  integer     mismatches, n_tests, i;
  // block with the core model on its table port
  csr_core_regs dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .dm_addr, .dm_indirect, .dm_bank, .dm_sfr_hit, .alu_go, .alu_op, .alu_opnd,
    .alu_to_work, .alu_result, .wdt_timeout(ev[0]), .wdt_clear(ev[1]),
    .sleep_exec(ev[2]), .soft_reset(ev[3]), .wdt_reset_in_sleep, .pc_step,
    .pc_value, .pc_dummy, .tbl_go, .tbl_addr, .tbl_word, .tbl_low_byte, .tbl_low_valid);
  // two-bank variant on the same inputs
  csr_core_regs #(.THREE_BANK(0)) dut2 (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata(rdata2), .dm_addr, .dm_indirect, .dm_bank(bank2), .dm_sfr_hit(),
    .alu_go, .alu_op, .alu_opnd, .alu_to_work, .alu_result(), .wdt_timeout(ev[0]),
    .wdt_clear(ev[1]), .sleep_exec(ev[2]), .soft_reset(ev[3]), .wdt_reset_in_sleep,
    .pc_step, .pc_value(), .pc_dummy(), .tbl_go, .tbl_addr(), .tbl_word(tbl_word),
    .tbl_low_byte(), .tbl_low_valid());
  csr_core_model core (.tbl_addr, .tbl_word);
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // byte compare
  task cmp(input [7:0] got, input [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // register port cycles, mapped offsets only
  task wr(input [7:0] ad, input [7:0] dt);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] ad);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    d2 = rdata2;
  endtask
  // one alu step, result sampled in its cycle
  task alu(input [2:0] op, input [7:0] x, input tw);
    @(posedge mclk);
    alu_go <= 1'b1;
    alu_op <= op;
    alu_opnd <= x;
    alu_to_work <= tw;
    #1 res = alu_result;
    @(posedge mclk);
    alu_go <= 1'b0;
  endtask
  // event pulses and data memory mapping
  task pulse(input [3:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 4'h0;
  endtask
  task map(input ind, input [7:0] ad);
    @(posedge mclk);
    dm_indirect <= ind;
    dm_addr <= ad;
    #1 d = {6'h00, dm_bank};
  endtask
  // arithmetic flags expected from add or subtract
  function [7:0] flags(input sub, input [7:0] x, input [7:0] y);
    reg [7:0] yy;
    reg [8:0] s;
    reg [4:0] n;
    begin
      yy = sub ? ~y : y;
      s = x + yy + sub;
      n = x[3:0] + yy[3:0] + sub;
      flags = {4'h0, s[8] ^ s[7] ^ x[7] ^ yy[7], s[7:0] == 8'h00, n[4], s[8]};
    end
  endfunction
  task end_of_test;
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, about four thousand cycles
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  // main sequence
  initial
  begin
    {reg_wr, reg_rd, dm_indirect, alu_go, alu_to_work, tbl_go, wdt_reset_in_sleep, pc_step} = 8'h00;
    {reg_addr, reg_wdata, dm_addr, alu_opnd, alu_op, ev} = 39'h0;
    nrst = 1'b0;
    mismatches = 0;
    n_tests = 0;
    i = $urandom(32'h01b76ea4);
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h0a); cmp(d, 8'h00);
    for (i = 0; i < 3; i = i + 1)
    begin
      wr(8'h04, 8'hfc | i);
      rd(8'h04); cmp(d, i);
      cmp(d2, i & 1);
      map(1'b1, 8'h80 | $urandom); cmp(d, i);
      cmp({6'h00, bank2}, i & 1);
      map(1'b0, 8'h80 | $urandom); cmp(d, 8'h00);
    end
    wr(8'h04, 8'h01);
    wdt_reset_in_sleep <= 1'b1;
    pulse(4'h8);
    rd(8'h04); cmp(d, 8'h01);
    wdt_reset_in_sleep <= 1'b0;
    pulse(4'h8);
    rd(8'h04); cmp(d, 8'h00);
    for (i = 0; i < 12; i = i + 1)
    begin
      a = (i < 2) ? 8'h80 : $urandom;
      b = (i < 2) ? 8'h80 : $urandom;
      alu(3'h7, a, 1'b1);
      alu(i[0], b, 1'b0); cmp(res, i[0] ? a - b : a + b);
      rd(8'h0a); cmp(d, flags(i[0], a, b));
    end
    alu(3'h0, b, 1'b1);
    rd(8'h05); cmp(d, a + b);
    wr(8'h0a, 8'hff);
    rd(8'h0a); cmp(d, 8'h0f);
    pulse(4'h4);
    rd(8'h0a); cmp(d, 8'h1f);
    pulse(4'h1);
    rd(8'h0a); cmp(d, 8'h3f);
    wr(8'h0a, 8'h00);
    rd(8'h0a); cmp(d, 8'h30);
    pulse(4'h4);
    rd(8'h0a); cmp(d, 8'h10);
    pulse(4'h2);
    rd(8'h0a); cmp(d, 8'h00);
    a = $urandom;
    b = $urandom;
    wr(8'h07, a);
    wr(8'h08, b);
    @(posedge mclk);
    tbl_go <= 1'b1;
    @(posedge mclk);
    tbl_go <= 1'b0;
    #1 cmp(tbl_low_byte, ~b);
    rd(8'h09); cmp(d, a ^ 8'h5a);
    wr(8'h06, a);
    pc_step <= 1'b1;
    #1 cmp(pc_value[7:0], a);
    cmp({7'h00, pc_dummy}, 8'h01);
    @(posedge mclk);
    #1 cmp(pc_value[7:0], a);
    @(posedge mclk);
    pc_step <= 1'b0;
    #1 cmp(pc_value[7:0], a + 8'h01);
    end_of_test;
  end
endmodule

// [test/csr_core_model.sv]
`timescale 1ns/100ps
module csr_core_model (
  // program memory side of a table read
  input  logic [15:0] tbl_addr,
  output logic [15:0] tbl_word
);
  // word scrambled from its address so both bytes differ
  assign tbl_word = {tbl_addr[7:0] ^ 8'h5a, ~tbl_addr[15:8]};
endmodule

// [test/csr_core_regs_sva.sv]
`timescale 1ns/100ps
module csr_core_regs_sva #(
  parameter PC_W = 13
) (
  // watched ports of the register block
  input logic            mclk,
  input logic            nrst,
  input logic [7:0]      reg_addr,
  input logic [7:0]      reg_wdata,
  input logic            reg_wr,
  input logic            reg_rd,
  input logic [7:0]      reg_rdata,
  input logic [7:0]      dm_addr,
  input logic            dm_indirect,
  input logic [1:0]      dm_bank,
  input logic            dm_sfr_hit,
  input logic [PC_W-1:0] pc_value,
  input logic            pc_dummy,
  input logic            tbl_go,
  input logic [15:0]     tbl_word,
  input logic [7:0]      tbl_low_byte,
  input logic            tbl_low_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // decoded register accesses
  wire pcl_wr = reg_wr && reg_addr == 8'h06;
  wire st_rd  = reg_rd && reg_addr == 8'h0a;
  property p_bank_pad; reg_rd && reg_addr == 8'h04 |=> reg_rdata[7:2] == 6'h00; endproperty
  a_bank_pad: assert property (p_bank_pad) else $error("bank pad bits set");
  property p_st_pad; st_rd |=> reg_rdata[7:6] == 2'h0; endproperty
  a_st_pad: assert property (p_st_pad) else $error("status pad bits set");
  property p_direct; !dm_indirect |-> dm_bank == 2'h0; endproperty
  a_direct: assert property (p_direct) else $error("direct access left bank 0");
  property p_sfr; dm_sfr_hit |-> dm_bank == 2'h0; endproperty
  a_sfr: assert property (p_sfr) else $error("special area banked");
  property p_sfr_map; dm_sfr_hit == (dm_addr <= 8'h7f); endproperty
  a_sfr_map: assert property (p_sfr_map) else $error("special area decode");
  property p_jump;
    pcl_wr |=> pc_value[7:0] == $past(reg_wdata) && pc_value[PC_W-1:8] == $past(pc_value[PC_W-1:8]);
  endproperty
  a_jump: assert property (p_jump) else $error("pc low write jump wrong");
  property p_dummy; pcl_wr |=> pc_dummy; endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy cycle");
  property p_tbl; tbl_go |=> tbl_low_valid && tbl_low_byte == $past(tbl_word[7:0]); endproperty
  a_tbl: assert property (p_tbl) else $error("table low byte wrong");
  // main scenarios reached
  c_jump: cover property (pcl_wr);
  c_bank2: cover property (dm_indirect && dm_bank == 2'h2);
  c_tbl: cover property (tbl_low_valid);
endmodule
bind csr_core_regs csr_core_regs_sva #(.PC_W(PC_W)) u_sva (.mclk, .nrst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .dm_addr, .dm_indirect, .dm_bank, .dm_sfr_hit, .pc_value,
  .pc_dummy, .tbl_go, .tbl_word, .tbl_low_byte, .tbl_low_valid);
